// *** hdl/dcdm_defs.svh ***
// Register offsets, field positions, reset values and counts of the descriptor data mover.
`ifndef DCDM_DEFS_SVH
`define DCDM_DEFS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DCDM_REG_CTRL      12'h000
`define DCDM_REG_RX_BASE   12'h004
`define DCDM_REG_TX_BASE   12'h008
`define DCDM_REG_THRESH    12'h00c
`define DCDM_REG_WIN_BASE  12'h010
`define DCDM_REG_WIN_MASK  12'h014
`define DCDM_REG_WIN_PORT  12'h018
`define DCDM_REG_OUT_OFFS  12'h01c
`define DCDM_REG_STATUS    12'h020
`define DCDM_REG_COUNTS    12'h024
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DCDM_CTRL_RX_EN    0
`define DCDM_CTRL_TX_EN    1
`define DCDM_CTRL_GLOBAL   2
`define DCDM_CTRL_RX_COH   3
`define DCDM_CTRL_TX_COH   4
`define DCDM_CTRL_CLS_LSB  5
`define DCDM_CTRL_CLS_MSB  6
`define DCDM_CTRL_RESET    32'h0000_0000
`define DCDM_THRESH_RESET  32'h0000_0402
// ----------------------------------------------------------------------------
// Descriptor layout: low word control, high word buffer address
// ----------------------------------------------------------------------------
`define DCDM_D_OWN         31
`define DCDM_D_LAST        30
`define DCDM_D_WRAP        29
`define DCDM_D_LEN_MSB     15
`define DCDM_DESC_BYTES    32'h0000_0008
`define DCDM_WORD_BYTES    16'h0008
// ----------------------------------------------------------------------------
// Fabric ports
// ----------------------------------------------------------------------------
`define DCDM_PORT_LOCAL    2'h0
`define DCDM_PORT_OFFCHIP  2'h2
`endif

// *** hdl/dcdm_pkg.sv ***
// Types shared by the descriptor data mover.
package dcdm_pkg;
  typedef enum logic [1:0] {
    DCDM_CLS_ATM,
    DCDM_CLS_MULTI,
    DCDM_CLS_FAST,
    DCDM_CLS_SERIAL
  } dcdm_class_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic        dir_tx;
  } dcdm_req_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  port_id;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic        snoop;
  } dcdm_mem_t;

  typedef struct packed {
    logic        last;
    logic [2:0]  nbytes_m1;
    logic [63:0] data;
  } dcdm_word_t;

  typedef enum {RX_IDLE, RX_FETCH, RX_MOVE, RX_CLOSE} dcdm_rx_state_t;
  typedef enum {TX_IDLE, TX_POLL, TX_LOAD, TX_CLOSE} dcdm_tx_state_t;
endpackage

// *** hdl/dcdm_data_mover.sv ***
// Descriptor-driven receive and transmit data mover with address translation and snoop control.
// Overview of operation
// - Receive bytes are parity decoded and unit ends delineated before buffering.
// - Received bytes become parallel words written into the receive FIFO.
// - Receive FIFO level reaching threshold raises a service request.
// - Service fetches the next receive descriptor from the programmed table pointer.
// - Staged words are written to the buffer, then the descriptor is closed.
// - A stored complete packet pulses the core event output.
// - Units longer than a buffer continue into further receive descriptors.
// - Transmit starts at the table pointer and polls the ready flag.
// - A ready buffer is read by DMA into the transmit FIFO.
// - Transmit FIFO draining to its low threshold requests more data.
// - Transmit words are serialized, encoded with parity and sent out.
// - Transmit continues across descriptors until the unit's last one is sent.
// - Window hits map the address to a fabric port and local address.
// - Off-chip destination ports add the outbound offset to the local address.
// - Receive bytes are packed into 64-bit words.
// - Transmit 64-bit words are unpacked into bytes.
// - Descriptor accesses use the same translation as data accesses.
// - Snoop is asserted only for global transactions.
// - ATM traffic coherency follows per-direction connection bits.
// - Multichannel traffic coherency follows the channel transfer state bits; the code uses the receive coherency bit for both directions.
// - Fast and serial traffic coherency follows per-direction function code bits.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "dcdm_defs.svh"
module dcdm_data_mover #(
  parameter int RX_DEPTH  = 16,
  parameter int TX_DEPTH  = 16,
  parameter int RING      = 64,
  parameter int BYTE_GAP  = 4,
  parameter int POLL_GAP  = 64
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [7:0]        rx_line_data,
  input  wire logic              rx_line_parity,
  input  wire logic              rx_line_end,
  input  wire logic              rx_line_strobe,
  output logic [7:0]             tx_line_data,
  output logic                   tx_line_parity,
  output logic                   tx_line_end,
  output logic                   tx_line_strobe,
  output dcdm_pkg::dcdm_mem_t    mem_o,
  input  wire logic              mem_ack,
  input  wire logic [63:0]       mem_rdata,
  output logic                   core_rx_event
);
  localparam int RXAW = $clog2(RX_DEPTH);
  localparam int TXAW = $clog2(TX_DEPTH);
  localparam int IW   = $clog2(RING);

  // --------------------------------------------------------------------------
  // Registers and APB slave
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q, rx_base_q, tx_base_q, thresh_q;
  logic [31:0] win_base_q, win_mask_q, win_port_q, out_offs_q;
  logic [15:0] parity_err_q, rx_units_q;
  logic [IW-1:0] rx_idx_q, tx_idx_q;
  logic [RXAW:0] rx_level;
  logic [TXAW:0] tx_level;
  logic          apb_wr;

  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= `DCDM_CTRL_RESET;
      rx_base_q  <= 32'h0000_0000;
      tx_base_q  <= 32'h0000_0000;
      thresh_q   <= `DCDM_THRESH_RESET;
      win_base_q <= 32'h0000_0000;
      win_mask_q <= 32'h0000_0000;
      win_port_q <= 32'h0000_0000;
      out_offs_q <= 32'h0000_0000;
    end else if (ce && apb_wr) begin
      unique case (paddr)
        `DCDM_REG_CTRL:     ctrl_q     <= pwdata;
        `DCDM_REG_RX_BASE:  rx_base_q  <= pwdata;
        `DCDM_REG_TX_BASE:  tx_base_q  <= pwdata;
        `DCDM_REG_THRESH:   thresh_q   <= pwdata;
        `DCDM_REG_WIN_BASE: win_base_q <= pwdata;
        `DCDM_REG_WIN_MASK: win_mask_q <= pwdata;
        `DCDM_REG_WIN_PORT: win_port_q <= pwdata;
        `DCDM_REG_OUT_OFFS: out_offs_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Reads are answered in the access phase with no wait state.
  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    unique case (paddr)
      `DCDM_REG_CTRL:     prdata = ctrl_q;
      `DCDM_REG_RX_BASE:  prdata = rx_base_q;
      `DCDM_REG_TX_BASE:  prdata = tx_base_q;
      `DCDM_REG_THRESH:   prdata = thresh_q;
      `DCDM_REG_WIN_BASE: prdata = win_base_q;
      `DCDM_REG_WIN_MASK: prdata = win_mask_q;
      `DCDM_REG_WIN_PORT: prdata = win_port_q;
      `DCDM_REG_OUT_OFFS: prdata = out_offs_q;
      `DCDM_REG_STATUS:   prdata = {8'(rx_idx_q), 8'(tx_idx_q), 8'(rx_level), 8'(tx_level)};
      `DCDM_REG_COUNTS:   prdata = {rx_units_q, parity_err_q};
      default:            pslverr = psel & penable;
    endcase
  end

  // --------------------------------------------------------------------------
  // Receive line: synchroniser, decode and packing
  // --------------------------------------------------------------------------
  logic [10:0] rx_s1_q, rx_s2_q;
  logic        rx_stb_seen_q;
  logic        rx_byte;
  logic [63:0] pack_q;
  logic [2:0]  pack_cnt_q;
  dcdm_pkg::dcdm_word_t rx_mem [RX_DEPTH];
  logic [RXAW:0] rx_wp_q, rx_rp_q;
  logic          rx_push, rx_pop, rx_full, rx_empty;
  logic [RXAW:0] rx_end_cnt_q;
  dcdm_pkg::dcdm_word_t rx_head;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1_q <= 11'h000;
      rx_s2_q <= 11'h000;
    end else if (ce) begin
      rx_s1_q <= {rx_line_strobe, rx_line_end, rx_line_parity, rx_line_data};
      rx_s2_q <= rx_s1_q;
    end
  end

  // Each byte is marked by a toggle of the strobe, so the byte fields are stable when seen.
  assign rx_byte = (rx_s2_q[10] != rx_stb_seen_q) && (^rx_s2_q[8:0] == 1'b0) && !rx_full;
  assign rx_push = rx_byte && (rx_s2_q[9] || pack_cnt_q == 3'h7);
  assign rx_full  = (rx_wp_q[RXAW] != rx_rp_q[RXAW]) && (rx_wp_q[RXAW-1:0] == rx_rp_q[RXAW-1:0]);
  assign rx_empty = rx_wp_q == rx_rp_q;
  assign rx_level = rx_wp_q - rx_rp_q;
  assign rx_head  = rx_mem[rx_rp_q[RXAW-1:0]];

  // A byte arriving while the FIFO is full is held back until space appears.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_stb_seen_q <= 1'b0;
      pack_q        <= 64'h0;
      pack_cnt_q    <= 3'h0;
      parity_err_q  <= 16'h0000;
    end else if (ce && rx_s2_q[10] != rx_stb_seen_q) begin
      if (^rx_s2_q[8:0] != 1'b0) begin
        rx_stb_seen_q <= rx_s2_q[10];
        parity_err_q  <= parity_err_q + 16'h0001;
      end else if (!rx_full) begin
        rx_stb_seen_q <= rx_s2_q[10];
        pack_q        <= rx_push ? 64'h0 : pack_q | (64'(rx_s2_q[7:0]) << (pack_cnt_q*8));
        pack_cnt_q    <= rx_s2_q[9] ? 3'h0 : pack_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_wp_q <= '0;
    end else if (ce && rx_push) begin
      rx_mem[rx_wp_q[RXAW-1:0]] <= '{last: rx_s2_q[9], nbytes_m1: pack_cnt_q,
                                     data: pack_q | (64'(rx_s2_q[7:0]) << (pack_cnt_q*8))};
      rx_wp_q <= rx_wp_q + 1'b1;
    end
  end

  // Counting queued unit ends lets a short unit be serviced below the threshold.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_end_cnt_q <= '0;
    end else if (ce) begin
      rx_end_cnt_q <= rx_end_cnt_q + (rx_push && rx_s2_q[9]) - (rx_pop && rx_head.last);
    end
  end

  // --------------------------------------------------------------------------
  // Receive descriptor engine
  // --------------------------------------------------------------------------
  dcdm_pkg::dcdm_rx_state_t rx_st_q;
  dcdm_pkg::dcdm_req_t      rx_req;
  logic [31:0] rx_buf_q;
  logic [15:0] rx_len_q, rx_off_q, rx_off_nx;
  logic        rx_wrap_q, rx_last_q, rx_ack, rx_service;
  logic [31:0] rx_desc_addr;

  assign rx_desc_addr = rx_base_q + 32'(rx_idx_q) * `DCDM_DESC_BYTES;
  assign rx_service   = (rx_level >= (RXAW+1)'(thresh_q[7:0])) || (rx_end_cnt_q != '0);
  assign rx_off_nx    = rx_off_q + 16'(rx_head.nbytes_m1) + 16'h0001;
  assign rx_pop       = rx_ack && rx_st_q == dcdm_pkg::RX_MOVE;

  always_comb begin
    rx_req = '0;
    unique case (rx_st_q)
      dcdm_pkg::RX_FETCH: begin
        rx_req.valid = 1'b1;
        rx_req.addr  = rx_desc_addr;
      end
      dcdm_pkg::RX_MOVE: begin
        rx_req.valid = !rx_empty;
        rx_req.we    = 1'b1;
        rx_req.addr  = rx_buf_q + 32'(rx_off_q);
        rx_req.wdata = rx_head.data;
      end
      dcdm_pkg::RX_CLOSE: begin
        rx_req.valid = 1'b1;
        rx_req.we    = 1'b1;
        rx_req.addr  = rx_desc_addr;
        rx_req.wdata = {rx_buf_q, 1'b0, rx_last_q, rx_wrap_q, 13'h0000, rx_off_q};
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_q       <= dcdm_pkg::RX_IDLE;
      rx_idx_q      <= '0;
      rx_buf_q      <= 32'h0000_0000;
      rx_len_q      <= 16'h0000;
      rx_off_q      <= 16'h0000;
      rx_wrap_q     <= 1'b0;
      rx_last_q     <= 1'b0;
      rx_rp_q       <= '0;
      core_rx_event <= 1'b0;
      rx_units_q    <= 16'h0000;
    end else if (ce) begin
      core_rx_event <= 1'b0;
      unique case (rx_st_q)
        dcdm_pkg::RX_IDLE:
          if (ctrl_q[`DCDM_CTRL_RX_EN] && rx_service) rx_st_q <= dcdm_pkg::RX_FETCH;
        dcdm_pkg::RX_FETCH:
          if (rx_ack) begin
            // A descriptor still owned by software is retried on the next service pass.
            if (mem_rdata[`DCDM_D_OWN]) begin
              rx_buf_q  <= mem_rdata[63:32];
              rx_len_q  <= mem_rdata[`DCDM_D_LEN_MSB:0];
              rx_wrap_q <= mem_rdata[`DCDM_D_WRAP];
              rx_off_q  <= 16'h0000;
              rx_st_q   <= dcdm_pkg::RX_MOVE;
            end else begin
              rx_st_q   <= dcdm_pkg::RX_IDLE;
            end
          end
        dcdm_pkg::RX_MOVE:
          if (rx_ack) begin
            rx_rp_q  <= rx_rp_q + 1'b1;
            rx_off_q <= rx_off_nx;
            if (rx_head.last) begin
              rx_last_q <= 1'b1;
              rx_st_q   <= dcdm_pkg::RX_CLOSE;
            end else if (rx_off_nx + `DCDM_WORD_BYTES > rx_len_q) begin
              rx_st_q   <= dcdm_pkg::RX_CLOSE;
            end
          end
        dcdm_pkg::RX_CLOSE:
          if (rx_ack) begin
            rx_idx_q      <= (rx_wrap_q || rx_idx_q == IW'(RING-1)) ? '0 : rx_idx_q + 1'b1;
            core_rx_event <= rx_last_q;
            rx_units_q    <= rx_units_q + 16'(rx_last_q);
            rx_last_q     <= 1'b0;
            rx_st_q       <= dcdm_pkg::RX_IDLE;
          end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Transmit descriptor engine and FIFO
  // --------------------------------------------------------------------------
  dcdm_pkg::dcdm_tx_state_t tx_st_q;
  dcdm_pkg::dcdm_req_t      tx_req;
  dcdm_pkg::dcdm_word_t     tx_mem [TX_DEPTH];
  logic [TXAW:0] tx_wp_q, tx_rp_q;
  logic          tx_full, tx_empty, tx_pop, tx_ack, tx_refill_q, tx_last_q, tx_wrap_q;
  logic [31:0]   tx_buf_q, tx_desc_addr;
  logic [15:0]   tx_len_q, tx_off_q, tx_rem;
  logic [15:0]   tx_gap_q;

  assign tx_full      = (tx_wp_q[TXAW] != tx_rp_q[TXAW]) && (tx_wp_q[TXAW-1:0] == tx_rp_q[TXAW-1:0]);
  assign tx_empty     = tx_wp_q == tx_rp_q;
  assign tx_level     = tx_wp_q - tx_rp_q;
  assign tx_desc_addr = tx_base_q + 32'(tx_idx_q) * `DCDM_DESC_BYTES;
  assign tx_rem       = tx_len_q - tx_off_q;

  // Refill starts at the low mark and runs until the FIFO is full, giving whole bursts.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_refill_q <= 1'b1;
    end else if (ce) begin
      if (tx_level <= (TXAW+1)'(thresh_q[15:8])) begin
        tx_refill_q <= 1'b1;
      end else if (tx_full) begin
        tx_refill_q <= 1'b0;
      end
    end
  end

  always_comb begin
    tx_req        = '0;
    tx_req.dir_tx = 1'b1;
    unique case (tx_st_q)
      dcdm_pkg::TX_POLL: begin
        tx_req.valid = 1'b1;
        tx_req.addr  = tx_desc_addr;
      end
      dcdm_pkg::TX_LOAD: begin
        tx_req.valid = tx_refill_q && !tx_full;
        tx_req.addr  = tx_buf_q + 32'(tx_off_q);
      end
      dcdm_pkg::TX_CLOSE: begin
        tx_req.valid = 1'b1;
        tx_req.we    = 1'b1;
        tx_req.addr  = tx_desc_addr;
        tx_req.wdata = {tx_buf_q, 1'b0, tx_last_q, tx_wrap_q, 13'h0000, tx_len_q};
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_q   <= dcdm_pkg::TX_IDLE;
      tx_idx_q  <= '0;
      tx_buf_q  <= 32'h0000_0000;
      tx_len_q  <= 16'h0000;
      tx_off_q  <= 16'h0000;
      tx_last_q <= 1'b0;
      tx_wrap_q <= 1'b0;
      tx_gap_q  <= 16'h0000;
      tx_wp_q   <= '0;
    end else if (ce) begin
      unique case (tx_st_q)
        dcdm_pkg::TX_IDLE:
          if (tx_gap_q != 16'h0000) begin
            tx_gap_q <= tx_gap_q - 16'h0001;
          end else if (ctrl_q[`DCDM_CTRL_TX_EN]) begin
            tx_st_q  <= dcdm_pkg::TX_POLL;
          end
        dcdm_pkg::TX_POLL:
          if (tx_ack) begin
            if (mem_rdata[`DCDM_D_OWN] && mem_rdata[`DCDM_D_LEN_MSB:0] != 16'h0000) begin
              tx_buf_q  <= mem_rdata[63:32];
              tx_len_q  <= mem_rdata[`DCDM_D_LEN_MSB:0];
              tx_last_q <= mem_rdata[`DCDM_D_LAST];
              tx_wrap_q <= mem_rdata[`DCDM_D_WRAP];
              tx_off_q  <= 16'h0000;
              tx_st_q   <= dcdm_pkg::TX_LOAD;
            end else begin
              tx_gap_q  <= 16'(POLL_GAP);
              tx_st_q   <= dcdm_pkg::TX_IDLE;
            end
          end
        dcdm_pkg::TX_LOAD:
          if (tx_ack) begin
            tx_mem[tx_wp_q[TXAW-1:0]] <= '{last: tx_last_q && tx_rem <= `DCDM_WORD_BYTES,
                                           nbytes_m1: (tx_rem < `DCDM_WORD_BYTES) ?
                                             3'(tx_rem - 16'h0001) : 3'h7,
                                           data: mem_rdata};
            tx_wp_q  <= tx_wp_q + 1'b1;
            tx_off_q <= tx_off_q + `DCDM_WORD_BYTES;
            if (tx_rem <= `DCDM_WORD_BYTES) tx_st_q <= dcdm_pkg::TX_CLOSE;
          end
        dcdm_pkg::TX_CLOSE:
          if (tx_ack) begin
            tx_idx_q <= (tx_wrap_q || tx_idx_q == IW'(RING-1)) ? '0 : tx_idx_q + 1'b1;
            tx_st_q  <= dcdm_pkg::TX_IDLE;
          end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Transmit serializer
  // --------------------------------------------------------------------------
  dcdm_pkg::dcdm_word_t ser_q;
  logic [2:0]  ser_cnt_q;
  logic        ser_busy_q;
  logic [15:0] ser_gap_q;

  assign tx_pop = !ser_busy_q && !tx_empty;

  always_ff @(posedge clk) begin
    if (rst) begin
      ser_q          <= '0;
      ser_cnt_q      <= 3'h0;
      ser_busy_q     <= 1'b0;
      ser_gap_q      <= 16'h0000;
      tx_rp_q        <= '0;
      tx_line_data   <= 8'h00;
      tx_line_parity <= 1'b0;
      tx_line_end    <= 1'b0;
      tx_line_strobe <= 1'b0;
    end else if (ce) begin
      if (tx_pop) begin
        ser_q      <= tx_mem[tx_rp_q[TXAW-1:0]];
        tx_rp_q    <= tx_rp_q + 1'b1;
        ser_cnt_q  <= 3'h0;
        ser_busy_q <= 1'b1;
      end else if (ser_busy_q) begin
        if (ser_gap_q != 16'h0000) begin
          ser_gap_q <= ser_gap_q - 16'h0001;
        end else begin
          tx_line_data   <= ser_q.data[ser_cnt_q*8 +: 8];
          tx_line_parity <= ^ser_q.data[ser_cnt_q*8 +: 8];
          tx_line_end    <= ser_q.last && ser_cnt_q == ser_q.nbytes_m1;
          tx_line_strobe <= ~tx_line_strobe;
          ser_gap_q      <= 16'(BYTE_GAP - 1);
          ser_cnt_q      <= ser_cnt_q + 3'h1;
          if (ser_cnt_q == ser_q.nbytes_m1) ser_busy_q <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Memory arbiter, address translation and coherency
  // --------------------------------------------------------------------------
  logic mem_sel_q;
  dcdm_pkg::dcdm_req_t win_req;
  logic        win_hit, snoop;
  logic [1:0]  port_id;
  logic [31:0] local_addr;

  assign win_req = rx_req.valid ? rx_req : tx_req;
  assign rx_ack  = mem_ack && mem_o.valid && !mem_sel_q;
  assign tx_ack  = mem_ack && mem_o.valid && mem_sel_q;

  // Descriptors and buffers go through the same window, so both may live across the fabric.
  always_comb begin
    win_hit    = (win_req.addr & win_mask_q) == (win_base_q & win_mask_q);
    port_id    = win_hit ? win_port_q[1:0] : `DCDM_PORT_LOCAL;
    local_addr = win_hit ? (win_req.addr & ~win_mask_q) : win_req.addr;
    if (port_id >= `DCDM_PORT_OFFCHIP) local_addr = local_addr + out_offs_q;
  end

  // Multichannel class takes the receive coherency bit for both directions; other classes use the per-direction bit.
  always_comb begin
    snoop = win_req.dir_tx ? ctrl_q[`DCDM_CTRL_TX_COH] : ctrl_q[`DCDM_CTRL_RX_COH];
    unique case (dcdm_pkg::dcdm_class_t'(ctrl_q[`DCDM_CTRL_CLS_MSB:`DCDM_CTRL_CLS_LSB]))
      dcdm_pkg::DCDM_CLS_MULTI: snoop = ctrl_q[`DCDM_CTRL_RX_COH];
      dcdm_pkg::DCDM_CLS_FAST, dcdm_pkg::DCDM_CLS_SERIAL: ;
      default: ;
    endcase
    snoop = snoop && ctrl_q[`DCDM_CTRL_GLOBAL];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_o     <= '0;
      mem_sel_q <= 1'b0;
    end else if (ce) begin
      if (mem_o.valid) begin
        if (mem_ack) mem_o.valid <= 1'b0;
      end else if (win_req.valid) begin
        mem_o     <= '{valid: 1'b1, we: win_req.we, port_id: port_id, addr: local_addr,
                       wdata: win_req.wdata, snoop: snoop};
        mem_sel_q <= !rx_req.valid;
      end
    end
  end
endmodule

// *** tb/dcdm_mem_model.sv ***
// Memory partner that answers the data mover's requests.
`timescale 1ns/10ps
module dcdm_mem_model (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire dcdm_pkg::dcdm_mem_t mem_o,
  input  wire logic [3:0]          lat,
  output logic                     mem_ack,
  output logic [63:0]              mem_rdata
);
  logic [63:0] mem [logic [31:0]];
  logic [3:0]  wait_q;
  // Read data is scrambled outside the ack so a late sample cannot pass.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_q <= 4'h0;
      mem_rdata <= 64'ha5a5_a5a5_a5a5_a5a5;
    end else if (mem_o.valid && !mem_ack) begin
      if (wait_q >= lat) begin
        wait_q <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_o.we)
          mem[mem_o.addr] = mem_o.wdata;
        else
          mem_rdata <= mem.exists(mem_o.addr) ? mem[mem_o.addr] : 64'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// *** tb/dcdm_chk.sv ***
// Port checker for the data mover.
`timescale 1ns/10ps
module dcdm_chk #(parameter int BYTE_GAP = 4) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [11:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         pwdata,
  input wire logic [7:0]          tx_line_data,
  input wire logic                tx_line_parity,
  input wire logic                tx_line_strobe,
  input wire dcdm_pkg::dcdm_mem_t mem_o,
  input wire logic                mem_ack,
  input wire logic                core_rx_event
);
  logic [3:0] ctrl_q;
  logic [7:0] gap_q;
  logic [1:0] wk_q;
  logic       strb_q;
  logic       tog;
  assign tog = tx_line_strobe != strb_q;
  always_ff @(posedge clk) begin
    if (rst)
      ctrl_q <= 4'h0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ctrl_q <= {pwdata[6:5], pwdata[3:2]};
  end
  // Gap count saturates so a long idle line never wraps into a false hit.
  always_ff @(posedge clk) begin
    strb_q <= rst ? 1'b0 : tx_line_strobe;
    if (rst)
      gap_q <= 8'hff;
    else if (tog)
      gap_q <= 8'h01;
    else if (gap_q < 8'hfe)
      gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    wk_q <= rst ? 2'h0 : {wk_q[0], mem_o.valid & mem_o.we & mem_ack};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence hold_s; mem_o.valid && !mem_ack; endsequence
  sequence take_s; mem_o.valid && mem_ack; endsequence
  req_stable_a: assert property (hold_s |=> mem_o.valid && $stable(mem_o))
    else $error("memory request moved before ack");
  req_drop_a: assert property (take_s |=> !mem_o.valid)
    else $error("memory request held after ack");
  snoop_global_a: assert property (mem_o.valid && !ctrl_q[0] |-> !mem_o.snoop)
    else $error("snoop without global attribute");
  snoop_multi_a: assert property (mem_o.valid && ctrl_q[3:2] == 2'h1
    |-> mem_o.snoop == (ctrl_q[0] & ctrl_q[1])) else $error("multichannel snoop wrong");
  tx_parity_a: assert property (tog |-> tx_line_parity == ^tx_line_data)
    else $error("transmit parity wrong");
  byte_gap_a: assert property (tog && gap_q != 8'hff |-> gap_q >= BYTE_GAP)
    else $error("transmit bytes too close");
  event_pulse_a: assert property (core_rx_event |=> !core_rx_event)
    else $error("event longer than one cycle");
  event_cause_a: assert property (core_rx_event |-> wk_q != 2'h0)
    else $error("event without close write");
endmodule
bind dcdm_data_mover dcdm_chk #(.BYTE_GAP(BYTE_GAP)) dcdm_chk_i (.*);

// *** tb/descriptor_channel_data_mover_test.sv ***
// Self-checking bench for the descriptor data mover.
`timescale 1ns/10ps
module descriptor_channel_data_mover_test;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, rerr, strb_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  rx_line_data, tx_line_data;
  logic        rx_line_parity, rx_line_end, rx_line_strobe, tx_line_parity;
  logic        tx_line_end, tx_line_strobe, mem_ack, core_rx_event;
  logic [63:0] mem_rdata;
  logic [3:0]  lat;
  logic [8:0]  txq[$];
  int          err_total, comparisons, evts;
  dcdm_pkg::dcdm_mem_t mem_o;
  dcdm_data_mover #(.RING(4), .POLL_GAP(8)) dcdm_data_mover_i (.*);
  dcdm_mem_model dcdm_mem_model_i (.*);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic e, input logic bad);
    rx_line_data <= d;
    rx_line_parity <= ^d ^ bad;
    rx_line_end <= e;
    repeat (4) @(posedge clk);
    rx_line_strobe <= !rx_line_strobe;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [63:0] m(input logic [31:0] a);
    return dcdm_mem_model_i.mem[a];
  endfunction
  task automatic close_out;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, monitors and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    strb_q <= tx_line_strobe;
    if (!rst && tx_line_strobe !== strb_q)
      txq.push_back({tx_line_end, tx_line_data});
    if (!rst && core_rx_event === 1'b1)
      evts++;
  end
  initial begin
    #300000;
    err_total++;
    close_out;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ce, lat, rst} = {47'h0, 1'b1, 4'h0, 1'b1};
    {rx_line_data, rx_line_parity, rx_line_end, rx_line_strobe} = 11'h0;
    dcdm_mem_model_i.mem[32'h0100_1000] = 64'h8000_2000_8000_0010;
    dcdm_mem_model_i.mem[32'h0100_1008] = 64'h8000_3000_8000_0010;
    dcdm_mem_model_i.mem[32'h4000] = 64'h0000_5000_8000_0008;
    dcdm_mem_model_i.mem[32'h4008] = 64'h0000_6000_c000_0003;
    dcdm_mem_model_i.mem[32'h5000] = 64'h1716_1514_1312_1110;
    dcdm_mem_model_i.mem[32'h6000] = 64'h0000_0000_001a_1918;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(12'h00c, 1'b0, 32'h0);
    chk(rdat, 32'h0402);
    apb(12'h040, 1'b0, 32'h0);
    chk({rerr, rdat}, 33'h1_0000_0000);
    apb(12'h010, 1'b1, 32'h8000_0000);
    apb(12'h014, 1'b1, 32'hf000_0000);
    apb(12'h018, 1'b1, 32'h2);
    apb(12'h01c, 1'b1, 32'h0100_0000);
    apb(12'h004, 1'b1, 32'h8000_1000);
    apb(12'h000, 1'b1, 32'h2d);
    for (int i = 0; i < 20; i++) begin
      if (i == 5)
        send(8'hee, 1'b0, 1'b1);
      send(8'h10 + i[7:0], i == 19, 1'b0);
    end
    for (int k = 0; k < 3000 && evts == 0; k++) @(posedge clk);
    chk(m(32'h0100_2000), 64'h1716_1514_1312_1110);
    chk(m(32'h0100_2008), 64'h1f1e_1d1c_1b1a_1918);
    chk(m(32'h0100_3000) & 64'hffff_ffff, 64'h2322_2120);
    chk(m(32'h0100_1000), 64'h8000_2000_0000_0010);
    chk(m(32'h0100_1008), 64'h8000_3000_4000_0004);
    chk(evts, 1);
    apb(12'h024, 1'b0, 32'h0);
    chk(rdat, 32'h0001_0001);
    lat <= 4'h3;
    apb(12'h008, 1'b1, 32'h4000);
    apb(12'h000, 1'b1, 32'h03);
    for (int k = 0; k < 3000 && txq.size() < 11; k++) @(posedge clk);
    for (int i = 0; i < 11; i++)
      chk(txq[i], {i == 10, 8'h10 + i[7:0]});
    chk(m(32'h4000), 64'h0000_5000_0000_0008);
    chk(m(32'h4008), 64'h0000_6000_4000_0003);
    close_out;
  end
endmodule
